// ### include/exec_cfg.svh
`ifndef EXEC_CFG_SVH
`define EXEC_CFG_SVH

// general register file index of the link register
`define LINK_REG_IDX 6'h3F
// pc bit that marks an odd word address
`define WORD_ADDR_BIT 2
// most load/store unit operations allowed in one bundle
`define LSU_MAX 3'h1
// bit of the breakpoint enable control that arms the breakpoint
`define BP_EN_BIT 0
// cycles between a control or status write and a breakpoint issue
`define BP_GAP_CYC 2'h2
// cycles before a jump may read a condition register result
`define JUMP_LAT_CYC 2
// cycles from issue until a conversion result is readable
`define RES_LAT_CYC 2
// divider operand width
`define DIV_WIDTH 32
// single precision exponent landmarks
`define FP_BIAS 8'h7F
`define FP_UNITY_EXP 8'h96
`define FP_SAT_EXP 8'h9E

`endif

// ### include/exec_pkg.sv
`default_nettype none
package exec_pkg;

    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_CMPLT = 4'h1,
        OP_CMPLTU = 4'h2,
        OP_CMPNE = 4'h3,
        OP_F2I = 4'h4,
        OP_I2F = 4'h5,
        OP_DIV = 4'h6,
        OP_DIVU = 4'h7,
        OP_SBRK = 4'h8,
        OP_DIB = 4'h9,
        OP_SPLICE1 = 4'hA,
        OP_SPLICE2 = 4'hB
    } op_t;

    typedef enum logic [2:0] {
        S_RUN = 3'h1,
        S_DIV = 3'h2,
        S_BPW = 3'h4
    } exec_state_t;

    typedef enum logic [2:0] {
        D_IDLE = 3'h1,
        D_RUN = 3'h2,
        D_DONE = 3'h4
    } div_state_t;

endpackage : exec_pkg
`default_nettype wire

// ### include/unit_req_if.sv
`timescale 1ns/1ps
`default_nettype none
interface unit_req_if #(parameter int W = 32);
    logic start;
    logic sel;
    logic [W-1:0] a;
    logic [W-1:0] b;
    logic done;
    logic [W-1:0] result;
    modport ctl (output start, sel, a, b, input done, result);
    modport unit (input start, sel, a, b, output done, result);
endinterface : unit_req_if
`default_nettype wire

// ### rtl/fp_int_conv.sv
`timescale 1ns/1ps
`default_nettype none
`include "exec_cfg.svh"
module fp_int_conv (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // sel high: float to int, low: int to float
    unit_req_if.unit req
);
    logic done_ff;
    logic [31:0] res_ff;
    logic [31:0] nxt_res;
    logic [7:0] f_exp;
    logic [31:0] f_mant;
    logic [31:0] f_mag;
    logic [31:0] f_int;
    logic [31:0] i_mag;
    logic [4:0] i_lz;
    logic [31:0] i_norm;
    logic [31:0] i_flt;

    function automatic logic [4:0] lead_zeros(input logic [31:0] v);
        lead_zeros = 5'h0;
        for (int i = 0; i < 32; i++) begin
            if (v[i]) begin
                lead_zeros = 5'(31 - i);
            end
        end
    endfunction : lead_zeros

    // float to int truncates toward zero and saturates out of range
    assign f_exp = req.a[30:23];
    assign f_mant = {8'h00, 1'b1, req.a[22:0]};
    assign f_mag = (f_exp >= `FP_UNITY_EXP) ? (f_mant << (f_exp - `FP_UNITY_EXP))
                                            : (f_mant >> (`FP_UNITY_EXP - f_exp));
    assign f_int = (f_exp < `FP_BIAS) ? 32'h0000_0000
                 : (f_exp >= `FP_SAT_EXP) ? (req.a[31] ? 32'h8000_0000 : 32'h7FFF_FFFF)
                 : (req.a[31] ? (~f_mag + 32'h0000_0001) : f_mag);
    // int to float truncates the low bits, no rounding
    assign i_mag = req.a[31] ? (~req.a + 32'h0000_0001) : req.a;
    assign i_lz = lead_zeros(i_mag);
    assign i_norm = i_mag << i_lz;
    assign i_flt = (req.a == 32'h0000_0000) ? 32'h0000_0000
                 : {req.a[31], `FP_SAT_EXP - {3'h0, i_lz}, i_norm[30:8]};
    assign nxt_res = req.sel ? f_int : i_flt;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            done_ff <= 1'b0;
            res_ff <= 32'h0000_0000;
        end else begin
            done_ff <= req.start;
            res_ff <= req.start ? nxt_res : res_ff;
        end
    end

    assign req.done = done_ff;
    assign req.result = res_ff;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_conv_one_cycle: assert property (req.start |=> req.done)
        else $error("conversion result not ready one cycle after start");
    a_i2f_sign_kept: assert property (req.start && !req.sel && req.a != 32'h0 |=>
        req.result[31] == $past(req.a[31]) && req.result[30:23] != 8'h00)
        else $error("int to float lost sign or exponent");
    a_f2i_small_zero: assert property (req.start && req.sel && req.a[30:23] < `FP_BIAS |=>
        req.result == 32'h0000_0000)
        else $error("float below one did not convert to zero");
endmodule : fp_int_conv
`default_nettype wire

// ### rtl/int_divider.sv
`timescale 1ns/1ps
`default_nettype none
`include "exec_cfg.svh"
module int_divider #(parameter int W = `DIV_WIDTH) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // sel high: signed quotient
    unit_req_if.unit req
);
    exec_pkg::div_state_t state_ff;
    exec_pkg::div_state_t nxt_state;
    logic [W-1:0] quo_ff;
    logic [W-1:0] rem_ff;
    logic [W-1:0] dvs_ff;
    logic [W-1:0] amag_ff;
    logic neg_ff;
    logic [$clog2(W)-1:0] cnt_ff;
    logic [W:0] shifted;
    logic [W+1:0] trial;
    logic fits;

    function automatic logic [W-1:0] cond_neg(input logic [W-1:0] v, input logic c);
        cond_neg = c ? (~v + {{(W-1){1'b0}}, 1'b1}) : v;
    endfunction : cond_neg

    // one quotient bit per cycle; the core stalls meanwhile
    // keep the remainder's top bit: divisors above half range need it
    assign shifted = {rem_ff, quo_ff[W-1]};
    assign trial = {1'b0, shifted} - {2'b00, dvs_ff};
    assign fits = !trial[W+1];

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            exec_pkg::D_IDLE: if (req.start) nxt_state = exec_pkg::D_RUN;
            exec_pkg::D_RUN: if (cnt_ff == ($clog2(W))'(W - 1)) nxt_state = exec_pkg::D_DONE;
            exec_pkg::D_DONE: nxt_state = exec_pkg::D_IDLE;
            default: nxt_state = exec_pkg::D_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_ff <= exec_pkg::D_IDLE;
            quo_ff <= '0;
            rem_ff <= '0;
            dvs_ff <= '0;
            amag_ff <= '0;
            neg_ff <= 1'b0;
            cnt_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            if (state_ff == exec_pkg::D_IDLE && req.start) begin
                quo_ff <= cond_neg(req.a, req.sel && req.a[W-1]);
                amag_ff <= cond_neg(req.a, req.sel && req.a[W-1]);
                dvs_ff <= cond_neg(req.b, req.sel && req.b[W-1]);
                neg_ff <= req.sel && (req.a[W-1] ^ req.b[W-1]);
                rem_ff <= '0;
                cnt_ff <= '0;
            end else if (state_ff == exec_pkg::D_RUN) begin
                rem_ff <= fits ? trial[W-1:0] : shifted[W-1:0];
                quo_ff <= {quo_ff[W-2:0], fits};
                cnt_ff <= cnt_ff + 1'b1;
            end
        end
    end

    // divide by zero gives all ones before the sign fix
    assign req.done = (state_ff == exec_pkg::D_DONE);
    assign req.result = cond_neg(quo_ff, neg_ff);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_div_exact: assert property (req.done && dvs_ff != '0 |->
        rem_ff < dvs_ff && ({{W{1'b0}}, quo_ff} * {{W{1'b0}}, dvs_ff} + {{W{1'b0}}, rem_ff})
        == {{W{1'b0}}, amag_ff})
        else $error("quotient and remainder do not rebuild the dividend");
    a_div_sign: assert property (req.done && neg_ff && quo_ff != '0 |-> req.result[W-1])
        else $error("signed quotient has wrong sign");
endmodule : int_divider
`default_nettype wire

// ### rtl/compare_convert_divide_ops.sv
// Operation
// - signed less-than on 32-bit two's complement
// - unsigned less-than on zero-extended operands
// - inequality test, immediate or register forms
// - jumps read condition result two cycles later
// - compares accepted anywhere, no result latency
// - float to signed integer conversion
// - signed integer to float conversion
// - conversions only at even word address
// - long results avoid link register, conversions two cycles
// - breakpoint enters debug or traps illegal
// - breakpoint waits two cycles after control writes
// - barrier and divides share one load/store unit
// - signed divide, pipeline stalls until ready
// - unsigned divide, pipeline stalls until ready
// - splice from byte one of sources
// - splice from byte two of sources
`timescale 1ns/1ps
`default_nettype none
`include "exec_cfg.svh"
module compare_convert_divide_ops (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // issue slot
    input wire logic issue_valid,
    input wire exec_pkg::op_t issue_op,
    input wire logic [31:0] issue_pc,
    input wire logic [31:0] src1,
    input wire logic [31:0] src2,
    input wire logic [31:0] imm,
    input wire logic use_imm,
    input wire logic dest_branch,
    input wire logic [5:0] gr_dest_in,
    input wire logic [2:0] br_dest_in,
    input wire logic [11:0] breakpoint_number,
    input wire logic [2:0] lsu_ops_in,
    // core state
    input wire logic [31:0] breakpoint_enable_control,
    input wire logic debug_mode,
    input wire logic ctrl_write,
    // pipeline control
    output logic stall_ff,
    // single cycle general register write
    output logic gr_wr_ff,
    output logic [5:0] gr_dest_ff,
    output logic [31:0] gr_data_ff,
    // conversion and division write
    output logic lat_wr_ff,
    output logic [5:0] lat_dest_ff,
    output logic [31:0] lat_data_ff,
    // condition register write
    output logic br_wr_ff,
    output logic [2:0] br_dest_ff,
    output logic br_val_ff,
    // condition visible to jumps
    output logic jump_rdy_ff,
    output logic [2:0] jump_dest_ff,
    output logic jump_val_ff,
    // events
    output logic software_breakpoint_event_ff,
    output logic [11:0] bp_number_ff,
    output logic illegal_opcode_trap_ff,
    output logic barrier_req_ff
);
    exec_pkg::exec_state_t state_ff;
    exec_pkg::exec_state_t nxt_state;
    logic [1:0] gap_ff;
    logic [11:0] held_bpn_ff;
    logic [5:0] div_dest_ff;
    logic [5:0] conv_dest_ff;

    unit_req_if #(.W(32)) div_bus ();
    unit_req_if #(.W(32)) conv_bus ();

    // decode
    wire acc = issue_valid && !stall_ff;
    wire [31:0] opnd2 = use_imm ? imm : src2;
    wire is_cmp = (issue_op == exec_pkg::OP_CMPLT) || (issue_op == exec_pkg::OP_CMPLTU)
                  || (issue_op == exec_pkg::OP_CMPNE);
    wire is_conv = (issue_op == exec_pkg::OP_F2I) || (issue_op == exec_pkg::OP_I2F);
    wire is_div = (issue_op == exec_pkg::OP_DIV) || (issue_op == exec_pkg::OP_DIVU);
    wire is_splice = (issue_op == exec_pkg::OP_SPLICE1) || (issue_op == exec_pkg::OP_SPLICE2);
    wire is_lsu = is_div || (issue_op == exec_pkg::OP_DIB);
    wire is_bp = (issue_op == exec_pkg::OP_SBRK);

    // compare results
    wire lt_s = $signed(src1) < $signed(opnd2);
    wire lt_u = src1 < opnd2;
    wire ne = src1 != opnd2;
    wire cmp_res = (issue_op == exec_pkg::OP_CMPLT) ? lt_s
                 : (issue_op == exec_pkg::OP_CMPLTU) ? lt_u : ne;

    // splices
    wire [31:0] splice_from_byte_one = {src2[7:0], src1[31:8]};
    wire [31:0] splice_from_byte_two = {src2[15:0], src1[31:16]};

    // illegal cases; compares carry no address or bundle check
    wire bad_conv = is_conv && issue_pc[`WORD_ADDR_BIT];
    wire bad_link = (is_conv || is_div) && (gr_dest_in == `LINK_REG_IDX);
    wire bad_lsu = is_lsu && (lsu_ops_in > `LSU_MAX);
    wire bad_ne = (issue_op == exec_pkg::OP_CMPNE) && use_imm && dest_branch;
    wire illegal_op = bad_conv || bad_link || bad_lsu || bad_ne;
    wire good = acc && !illegal_op;

    // breakpoint gating
    wire bp_blocked = (gap_ff != 2'h0) || ctrl_write;
    wire bp_armed = breakpoint_enable_control[`BP_EN_BIT] && !debug_mode;
    wire bp_now = (acc && is_bp && !bp_blocked) || (state_ff == exec_pkg::S_BPW && !bp_blocked);
    wire [11:0] bpn_sel = (state_ff == exec_pkg::S_BPW) ? held_bpn_ff : breakpoint_number;

    // single cycle results
    wire nxt_gr_wr = good && ((is_cmp && !dest_branch) || is_splice);
    wire [31:0] nxt_gr_data = (issue_op == exec_pkg::OP_SPLICE1) ? splice_from_byte_one
                            : (issue_op == exec_pkg::OP_SPLICE2) ? splice_from_byte_two
                            : {31'h0000_0000, cmp_res};

    // sub units
    assign div_bus.start = good && is_div && (state_ff == exec_pkg::S_RUN);
    assign div_bus.sel = (issue_op == exec_pkg::OP_DIV);
    assign div_bus.a = src1;
    assign div_bus.b = src2;
    assign conv_bus.start = good && is_conv;
    assign conv_bus.sel = (issue_op == exec_pkg::OP_F2I);
    assign conv_bus.a = src1;
    assign conv_bus.b = 32'h0000_0000;

    int_divider #(.W(32)) u_div (
        .clk(clk),
        .nrst(nrst),
        .req(div_bus.unit)
    );

    fp_int_conv u_conv (
        .clk(clk),
        .nrst(nrst),
        .req(conv_bus.unit)
    );

    // stall while a divide runs or a breakpoint waits out its gap
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            exec_pkg::S_RUN: begin
                if (div_bus.start) begin
                    nxt_state = exec_pkg::S_DIV;
                end else if (acc && is_bp && bp_blocked) begin
                    nxt_state = exec_pkg::S_BPW;
                end
            end
            exec_pkg::S_DIV: if (div_bus.done) nxt_state = exec_pkg::S_RUN;
            exec_pkg::S_BPW: if (!bp_blocked) nxt_state = exec_pkg::S_RUN;
            default: nxt_state = exec_pkg::S_RUN;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_ff <= exec_pkg::S_RUN;
            stall_ff <= 1'b0;
            gap_ff <= 2'h0;
            held_bpn_ff <= 12'h000;
        end else begin
            state_ff <= nxt_state;
            stall_ff <= (nxt_state != exec_pkg::S_RUN);
            gap_ff <= ctrl_write ? (`BP_GAP_CYC - 2'h1) : (gap_ff != 2'h0 ? gap_ff - 2'h1 : 2'h0);
            held_bpn_ff <= (acc && is_bp) ? breakpoint_number : held_bpn_ff;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            gr_wr_ff <= 1'b0;
            gr_dest_ff <= 6'h00;
            gr_data_ff <= 32'h0000_0000;
            br_wr_ff <= 1'b0;
            br_dest_ff <= 3'h0;
            br_val_ff <= 1'b0;
        end else begin
            gr_wr_ff <= nxt_gr_wr;
            gr_dest_ff <= nxt_gr_wr ? gr_dest_in : gr_dest_ff;
            gr_data_ff <= nxt_gr_wr ? nxt_gr_data : gr_data_ff;
            br_wr_ff <= good && is_cmp && dest_branch;
            br_dest_ff <= (good && is_cmp && dest_branch) ? br_dest_in : br_dest_ff;
            br_val_ff <= (good && is_cmp && dest_branch) ? cmp_res : br_val_ff;
        end
    end

    // jumps see the condition one cycle after other readers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            jump_rdy_ff <= 1'b0;
            jump_dest_ff <= 3'h0;
            jump_val_ff <= 1'b0;
        end else begin
            jump_rdy_ff <= br_wr_ff;
            jump_dest_ff <= br_wr_ff ? br_dest_ff : jump_dest_ff;
            jump_val_ff <= br_wr_ff ? br_val_ff : jump_val_ff;
        end
    end

    // long results: conversion issue+2, division when the divider finishes
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            conv_dest_ff <= 6'h00;
            div_dest_ff <= 6'h00;
            lat_wr_ff <= 1'b0;
            lat_dest_ff <= 6'h00;
            lat_data_ff <= 32'h0000_0000;
        end else begin
            conv_dest_ff <= conv_bus.start ? gr_dest_in : conv_dest_ff;
            div_dest_ff <= div_bus.start ? gr_dest_in : div_dest_ff;
            lat_wr_ff <= conv_bus.done || div_bus.done;
            lat_dest_ff <= conv_bus.done ? conv_dest_ff : (div_bus.done ? div_dest_ff : lat_dest_ff);
            lat_data_ff <= conv_bus.done ? conv_bus.result
                         : (div_bus.done ? div_bus.result : lat_data_ff);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            software_breakpoint_event_ff <= 1'b0;
            bp_number_ff <= 12'h000;
            illegal_opcode_trap_ff <= 1'b0;
            barrier_req_ff <= 1'b0;
        end else begin
            software_breakpoint_event_ff <= bp_now && bp_armed;
            bp_number_ff <= bp_now ? bpn_sel : bp_number_ff;
            illegal_opcode_trap_ff <= (acc && illegal_op) || (bp_now && !bp_armed);
            barrier_req_ff <= good && (issue_op == exec_pkg::OP_DIB);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_lt_signed: assert property (acc && issue_op == exec_pkg::OP_CMPLT && !dest_branch |=>
        gr_wr_ff && gr_data_ff[0] == ($signed($past(src1)) < $signed($past(opnd2))))
        else $error("signed less-than result wrong");
    a_lt_unsigned: assert property (acc && issue_op == exec_pkg::OP_CMPLTU |=>
        ($past(dest_branch) ? (br_wr_ff && br_val_ff == ($past(src1) < $past(opnd2)))
        : (gr_wr_ff && gr_data_ff[0] == ($past(src1) < $past(opnd2)))))
        else $error("unsigned less-than result wrong");
    a_ne_result: assert property (acc && issue_op == exec_pkg::OP_CMPNE && !use_imm && dest_branch |=>
        br_wr_ff && br_val_ff == ($past(src1) != $past(src2)))
        else $error("inequality result wrong");
    a_jump_delay: assert property (good && is_cmp && dest_branch |=> br_wr_ff ##1
        jump_rdy_ff && jump_val_ff == $past(br_val_ff) && jump_dest_ff == $past(br_dest_ff))
        else $error("jump saw condition at wrong cycle");
    a_cmp_accept: assert property (acc && is_cmp && !bad_ne |=> !illegal_opcode_trap_ff)
        else $error("compare refused");
    a_conv_odd: assert property (acc && is_conv && issue_pc[`WORD_ADDR_BIT] |=>
        illegal_opcode_trap_ff ##1 !lat_wr_ff)
        else $error("conversion at odd word taken");
    a_long_latency: assert property (good && is_conv |-> ##2 lat_wr_ff
        && lat_dest_ff == $past(gr_dest_in, 2) && lat_dest_ff != `LINK_REG_IDX)
        else $error("conversion result not written two cycles after issue");
    a_bp_entry: assert property (acc && is_bp && !bp_blocked |=>
        software_breakpoint_event_ff != illegal_opcode_trap_ff
        && software_breakpoint_event_ff == $past(bp_armed))
        else $error("breakpoint outcome wrong");
    a_bp_gap: assert property (ctrl_write |=> !software_breakpoint_event_ff [*2])
        else $error("breakpoint fired inside control write gap");
    a_lsu_single: assert property (acc && is_lsu && lsu_ops_in > `LSU_MAX |=>
        illegal_opcode_trap_ff && !stall_ff && !barrier_req_ff)
        else $error("second load/store unit operation taken");
    a_div_stall: assert property (div_bus.start |=> stall_ff [*8])
        else $error("divide did not hold the pipeline");
    a_splice_one: assert property (good && issue_op == exec_pkg::OP_SPLICE1 |=>
        gr_data_ff == {$past(src2[7:0]), $past(src1[31:8])})
        else $error("byte one splice wrong");
    a_splice_two: assert property (good && issue_op == exec_pkg::OP_SPLICE2 |=>
        gr_data_ff[15:0] == $past(src1[31:16]) && gr_data_ff[31:16] == $past(src2[15:0]))
        else $error("byte two splice wrong");
    a_cmp_gr_bits: assert property (good && is_cmp && !dest_branch |=>
        gr_data_ff[31:1] == 31'h0000_0000)
        else $error("compare wrote upper bits");

    c_div_done: cover property (div_bus.start ##[1:40] lat_wr_ff);
    c_bp_held: cover property (state_ff == exec_pkg::S_BPW ##1 software_breakpoint_event_ff);
    c_jump_cond: cover property (br_wr_ff ##1 jump_rdy_ff && jump_val_ff);
    c_conv_write: cover property (conv_bus.start ##2 lat_wr_ff);
endmodule : compare_convert_divide_ops
`default_nettype wire

// ### verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk, nrst, issue_valid, use_imm, dest_branch, debug_mode, ctrl_write;
    exec_pkg::op_t issue_op;
    logic [31:0] issue_pc, src1, src2, imm, breakpoint_enable_control;
    logic [5:0] gr_dest_in;
    logic [2:0] br_dest_in, lsu_ops_in;
    logic [11:0] breakpoint_number;
    logic stall_ff, gr_wr_ff, lat_wr_ff, br_wr_ff, br_val_ff, jump_rdy_ff, jump_val_ff;
    logic software_breakpoint_event_ff, illegal_opcode_trap_ff, barrier_req_ff;
    logic [5:0] gr_dest_ff, lat_dest_ff;
    logic [31:0] gr_data_ff, lat_data_ff;
    logic [2:0] br_dest_ff, jump_dest_ff;
    logic [11:0] bp_number_ff;
    int num_errors = 0;
    int n_tests = 0;
    compare_convert_divide_ops compare_convert_divide_ops_i (.clk(clk), .nrst(nrst), .issue_valid(issue_valid),
        .issue_op(issue_op), .issue_pc(issue_pc), .src1(src1), .src2(src2), .imm(imm), .use_imm(use_imm),
        .dest_branch(dest_branch), .gr_dest_in(gr_dest_in), .br_dest_in(br_dest_in),
        .breakpoint_number(breakpoint_number), .lsu_ops_in(lsu_ops_in),
        .breakpoint_enable_control(breakpoint_enable_control), .debug_mode(debug_mode),
        .ctrl_write(ctrl_write), .stall_ff(stall_ff), .gr_wr_ff(gr_wr_ff), .gr_dest_ff(gr_dest_ff),
        .gr_data_ff(gr_data_ff), .lat_wr_ff(lat_wr_ff), .lat_dest_ff(lat_dest_ff), .lat_data_ff(lat_data_ff),
        .br_wr_ff(br_wr_ff), .br_dest_ff(br_dest_ff), .br_val_ff(br_val_ff), .jump_rdy_ff(jump_rdy_ff),
        .jump_dest_ff(jump_dest_ff), .jump_val_ff(jump_val_ff),
        .software_breakpoint_event_ff(software_breakpoint_event_ff), .bp_number_ff(bp_number_ff),
        .illegal_opcode_trap_ff(illegal_opcode_trap_ff), .barrier_req_ff(barrier_req_ff));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task complete_run;
        $display("tests %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task step;
        @(posedge clk) #1;
    endtask : step
    // one op sampled at one edge; inputs move only 1 ns after an edge
    task issue(input exec_pkg::op_t op, input logic [31:0] a, input logic [31:0] b);
        step;
        ctrl_write = 1'b0;
        issue_valid = 1'b1;
        issue_op = op;
        src1 = a;
        src2 = b;
        step;
        issue_valid = 1'b0;
    endtask : issue
    task t_cmp_gr;
        gr_dest_in = 6'h05;
        issue(exec_pkg::OP_CMPLT, 32'hFFFFFFFF, 32'h00000001);
        chk(gr_wr_ff, 32'h1); chk(gr_data_ff, 32'h00000001); chk(gr_dest_ff, 32'h5);
        issue(exec_pkg::OP_CMPLTU, 32'hFFFFFFFF, 32'h00000001); step;
        chk(gr_data_ff, 32'h00000000);
        use_imm = 1'b1;
        imm = 32'hFFFFFFFF;
        issue(exec_pkg::OP_CMPLT, 32'h00000003, 32'h00000000); step;
        chk(gr_data_ff, 32'h00000000);
        issue(exec_pkg::OP_CMPLTU, 32'h00000003, 32'h00000000); step;
        chk(gr_data_ff, 32'h00000001);
        issue(exec_pkg::OP_CMPNE, 32'hFFFFFFFF, 32'h00000000); step;
        chk(gr_data_ff, 32'h00000000);
        use_imm = 1'b0;
        issue(exec_pkg::OP_CMPNE, 32'h00000010, 32'h00000011); step;
        chk(gr_data_ff, 32'h00000001);
        $display("compare to register done");
    endtask : t_cmp_gr
    task t_cmp_br;
        dest_branch = 1'b1;
        br_dest_in = 3'h3;
        issue_pc = 32'h00000104;
        issue(exec_pkg::OP_CMPNE, 32'h00000001, 32'h00000002);
        chk(br_wr_ff, 32'h1); chk(br_val_ff, 32'h1); chk(br_dest_ff, 32'h3);
        chk(jump_rdy_ff, 32'h0);
        step;
        chk(jump_rdy_ff, 32'h1); chk(jump_val_ff, 32'h1); chk(jump_dest_ff, 32'h3);
        issue(exec_pkg::OP_CMPLT, 32'h80000000, 32'h7FFFFFFF);
        chk(br_val_ff, 32'h1); chk(illegal_opcode_trap_ff, 32'h0);
        use_imm = 1'b1;
        issue(exec_pkg::OP_CMPNE, 32'h00000001, 32'h00000000);
        chk(illegal_opcode_trap_ff, 32'h1); chk(br_wr_ff, 32'h0);
        use_imm = 1'b0;
        dest_branch = 1'b0;
        issue_pc = 32'h00000100;
        $display("compare to condition done");
    endtask : t_cmp_br
    task t_splice;
        issue(exec_pkg::OP_SPLICE1, 32'h44332211, 32'h88776655); step;
        chk(gr_data_ff, 32'h55443322);
        issue(exec_pkg::OP_SPLICE2, 32'h44332211, 32'h88776655); step;
        chk(gr_data_ff, 32'h66554433);
        $display("splice done");
    endtask : t_splice
    task t_conv;
        gr_dest_in = 6'h0A;
        issue(exec_pkg::OP_I2F, 32'hFFFFFFFE, 32'h0);
        chk(lat_wr_ff, 32'h0); step;
        chk(lat_wr_ff, 32'h1); chk(lat_data_ff, 32'hC0000000); chk(lat_dest_ff, 32'hA);
        issue(exec_pkg::OP_F2I, 32'hC0E00000, 32'h0); step; step;
        chk(lat_data_ff, 32'hFFFFFFF9);
        issue_pc = 32'h00000104;
        issue(exec_pkg::OP_F2I, 32'h40400000, 32'h0);
        chk(illegal_opcode_trap_ff, 32'h1); step;
        chk(lat_wr_ff, 32'h0);
        issue_pc = 32'h00000100;
        gr_dest_in = 6'h3F;
        issue(exec_pkg::OP_I2F, 32'h00000001, 32'h0);
        chk(illegal_opcode_trap_ff, 32'h1);
        gr_dest_in = 6'h0A;
        $display("conversion done");
    endtask : t_conv
    task t_div(input exec_pkg::op_t op, input logic [31:0] a, input logic [31:0] b, input logic [31:0] q);
        int n;
        issue(op, a, b);
        n = 0;
        while (lat_wr_ff !== 1'b1) begin
            step;
            n++;
            if (n == 1) chk(stall_ff, 32'h1);
            if (n > 40) begin
                num_errors++;
                complete_run;
            end
        end
        chk(n, 33); chk(lat_data_ff, q); chk(stall_ff, 32'h0);
    endtask : t_div
    task t_lsu;
        t_div(exec_pkg::OP_DIV, 32'hFFFFFFF9, 32'h00000002, 32'hFFFFFFFD);
        t_div(exec_pkg::OP_DIVU, 32'hFFFFFFF9, 32'h00000002, 32'h7FFFFFFC);
        issue(exec_pkg::OP_DIB, 32'h0, 32'h0);
        chk(barrier_req_ff, 32'h1);
        lsu_ops_in = 3'h2;
        issue(exec_pkg::OP_DIVU, 32'h8, 32'h2);
        chk(illegal_opcode_trap_ff, 32'h1); chk(stall_ff, 32'h0);
        lsu_ops_in = 3'h1;
        $display("load store unit ops done");
    endtask : t_lsu
    task t_brk;
        breakpoint_number = 12'hABC;
        issue(exec_pkg::OP_SBRK, 32'h0, 32'h0);
        chk(software_breakpoint_event_ff, 32'h1); chk(bp_number_ff, 32'hABC);
        debug_mode = 1'b1;
        issue(exec_pkg::OP_SBRK, 32'h0, 32'h0);
        chk(illegal_opcode_trap_ff, 32'h1); chk(software_breakpoint_event_ff, 32'h0);
        debug_mode = 1'b0;
        step;
        ctrl_write = 1'b1;
        issue(exec_pkg::OP_SBRK, 32'h0, 32'h0);
        chk(stall_ff, 32'h1); chk(software_breakpoint_event_ff, 32'h0); step;
        chk(software_breakpoint_event_ff, 32'h1); chk(stall_ff, 32'h0);
        breakpoint_enable_control = 32'h00000000;
        issue(exec_pkg::OP_SBRK, 32'h0, 32'h0);
        chk(illegal_opcode_trap_ff, 32'h1);
        $display("breakpoint done");
    endtask : t_brk
    initial begin
        nrst = 1'b0; issue_valid = 1'b0; issue_op = exec_pkg::OP_NONE; issue_pc = 32'h00000100;
        src1 = 32'h0; src2 = 32'h0; imm = 32'h0; use_imm = 1'b0; dest_branch = 1'b0;
        gr_dest_in = 6'h01; br_dest_in = 3'h0; breakpoint_number = 12'h000; lsu_ops_in = 3'h1;
        breakpoint_enable_control = 32'h00000001; debug_mode = 1'b0; ctrl_write = 1'b0;
        repeat (12) @(posedge clk);
        #1 nrst = 1'b1;
        t_cmp_gr;
        t_cmp_br;
        t_splice;
        t_conv;
        t_lsu;
        t_brk;
        complete_run;
    end
endmodule : testbench
`default_nettype wire
